// File: core/sensor_serial_port.sv
// Purpose: four-wire serial port of a three-axis sensor, spi mode 0 or i2c target
// Assumes: pins sampled by 100 MHz clk; serial clock at most 10 MHz
// Notes: register storage lives outside; this block drives a byte-wide register port
`timescale 1ns/10ps
`default_nettype none
module sensor_serial_port
  import sensor_port_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter logic [9:0] FIFO_ADDR = FIFO_ADDR_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_scl_pin,
  input wire logic sclk_pin,
  input wire logic mosi_sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic miso_i2c_addr_select_pin_in,
  output logic miso_out,
  output logic miso_oe_n,
  output logic [9:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [FIFO_WORD_W-1:0] sample_data,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic i2c_mode
);
  initial begin
    if (FIFO_ADDR > ADDR_TOP) $error("fifo address out of range");
  end
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] cs_s1_reg, cs_s2_reg;
  logic [1:0] sck_s1_reg, sck_s2_reg;
  logic [1:0] din_s1_reg, din_s2_reg;
  logic i2c_addr_select_pin_s1_reg, i2c_addr_select_pin_s2_reg;
  logic cs_s2_q;
  logic sck_s2_q;
  logic din_s2_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s1_reg <= '1;
      sck_s1_reg <= '0;
      din_s1_reg <= '1;
      i2c_addr_select_pin_s1_reg <= 1'b0;
      i2c_addr_select_pin_s2_reg <= 1'b0;
    end else begin
      cs_s1_reg <= {cs_s1_reg[0], cs_scl_pin};
      sck_s1_reg <= {sck_s1_reg[0], sclk_pin};
      din_s1_reg <= {din_s1_reg[0], mosi_sda_in};
      i2c_addr_select_pin_s1_reg <= miso_i2c_addr_select_pin_in;
      i2c_addr_select_pin_s2_reg <= i2c_addr_select_pin_s1_reg;
    end
  end
  // second stage is [1], previous value kept separately for edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_s2_q <= 1'b1;
      sck_s2_q <= 1'b0;
      din_s2_q <= 1'b1;
    end else begin
      cs_s2_q <= cs_s1_reg[1];
      sck_s2_q <= sck_s1_reg[1];
      din_s2_q <= din_s1_reg[1];
    end
  end
  assign cs_s2_reg = {cs_s1_reg[1], cs_s2_q};
  assign sck_s2_reg = {sck_s1_reg[1], sck_s2_q};
  assign din_s2_reg = {din_s1_reg[1], din_s2_q};
  // spi clock pin grounded in i2c; i2c is chosen by a start (sda falling, cs/scl high), sclk is not looked at
  wire cs_now = cs_s2_reg[1];
  wire scl_rise = cs_s2_reg[1] && !cs_s2_reg[0];
  wire scl_fall = !cs_s2_reg[1] && cs_s2_reg[0];
  wire sck_rise = sck_s2_reg[1] && !sck_s2_reg[0];
  wire sck_fall = !sck_s2_reg[1] && sck_s2_reg[0];
  wire sda_now = din_s2_reg[1];
  wire i2c_start = cs_now && din_s2_reg[0] && !sda_now;
  wire i2c_stop = cs_now && !din_s2_reg[0] && sda_now;
  wire [6:0] own_addr = i2c_addr_select_pin_s2_reg ? I2C_ADDR_HIGH : I2C_ADDR_LOW;
  // ----------------------------------------------------------------
  // protocol detection
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_SPI = 3'b010,
    M_I2C = 3'b100
  } mode_t;
  mode_t mode_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= M_IDLE;
    end else begin
      case (mode_reg)
        M_IDLE: if (i2c_start) mode_reg <= M_I2C;
          else if (!cs_now) mode_reg <= M_SPI;
        M_SPI: if (cs_now) mode_reg <= M_IDLE;
        M_I2C: if (i2c_stop) mode_reg <= M_IDLE;
        default: mode_reg <= M_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // shared byte engine
  // ----------------------------------------------------------------
  logic [7:0] sh_reg;
  logic [3:0] bit_reg;
  logic [1:0] phase_reg; // 0 command/address, 1 reg address, 2 data
  logic rd_reg;
  logic ack_reg;
  logic ack_drive_reg; // this device pulls the ack bit low
  logic [9:0] addr_reg;
  logic fifo_run_reg;
  logic [1:0] pop_cnt_reg;
  logic [FIFO_WORD_W+2:0] fifo_word_reg;
  logic [7:0] tx_reg;
  logic sda_drive_reg;
  logic [FIFO_WORD_W-1:0] q_data;
  logic q_valid;
  logic q_pop;
  sample_fifo #(.WIDTH(FIFO_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(sample_data),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop)
  );
  wire spi_on = mode_reg == M_SPI;
  wire i2c_on = mode_reg == M_I2C;
  wire in_edge = spi_on ? sck_rise : (i2c_on && scl_rise);
  wire out_edge = spi_on ? sck_fall : (i2c_on && scl_fall);
  wire [7:0] sh_next = {sh_reg[6:0], sda_now};
  wire byte_done = in_edge && bit_reg == 4'd7;
  wire at_fifo = addr_reg == FIFO_ADDR;
  // next address after a data byte
  function automatic logic [9:0] step_addr(input logic [9:0] a);
    if (a == FIFO_ADDR || a == ADDR_TOP) step_addr = a;
    else step_addr = a + 10'h001;
  endfunction : step_addr
  // fifo word: 20 data bits, two zero bits, empty flag, x marker
  wire [23:0] fifo_bytes = {q_data[FIFO_WORD_W-1:1], 2'b00, !q_valid, q_data[XMARK_BIT]};
  // later bytes come from the latched word, the fifo has already moved on
  wire [7:0] byte_src = at_fifo ? (pop_cnt_reg == 2'd0 ? fifo_bytes[23:16] :
    pop_cnt_reg == 2'd1 ? fifo_word_reg[15:8] : fifo_word_reg[7:0]) : reg_rdata;
  wire load_tx = (phase_reg == 2'd2) && rd_reg && bit_reg == 4'd0 && !ack_reg;
  assign q_pop = load_tx && out_edge && at_fifo && pop_cnt_reg == 2'd0 && q_valid;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sh_reg <= 8'h00;
      bit_reg <= 4'h0;
      phase_reg <= 2'd0;
      rd_reg <= 1'b0;
      ack_reg <= 1'b0;
      ack_drive_reg <= 1'b0;
      addr_reg <= 10'h000;
      pop_cnt_reg <= 2'd0;
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      reg_wdata <= 8'h00;
    end else begin
      reg_write <= 1'b0;
      reg_read <= 1'b0;
      if (mode_reg == M_IDLE || i2c_start) begin
        bit_reg <= 4'h0;
        phase_reg <= 2'd0;
        ack_reg <= 1'b0;
        pop_cnt_reg <= 2'd0;
      end else if (spi_on && in_edge) begin
        sh_reg <= sh_next;
        bit_reg <= (bit_reg == 4'd7) ? 4'd0 : bit_reg + 4'd1;
        if (byte_done) begin
          case (phase_reg)
            2'd0: begin // 7-bit address then read flag
              addr_reg <= {3'b000, sh_next[7:1]};
              rd_reg <= sh_next[0];
              phase_reg <= 2'd2;
              reg_read <= sh_next[0];
            end
            default: begin
              if (!rd_reg) begin
                reg_wdata <= sh_next;
                reg_write <= 1'b1;
              end
              addr_reg <= step_addr(addr_reg);
              pop_cnt_reg <= !at_fifo ? 2'd0 : (pop_cnt_reg == 2'd2) ? 2'd0 : pop_cnt_reg + 2'd1;
              reg_read <= rd_reg;
            end
          endcase
        end
      end else if (i2c_on && in_edge) begin
        if (ack_reg) begin
          ack_reg <= 1'b0;
          if (rd_reg && phase_reg == 2'd2 && sda_now) phase_reg <= 2'd3; // nack ends read
        end else begin
          sh_reg <= sh_next;
          bit_reg <= (bit_reg == 4'd7) ? 4'd0 : bit_reg + 4'd1;
          if (byte_done) begin
            ack_reg <= 1'b1;
            ack_drive_reg <= (phase_reg == 2'd1) || (phase_reg == 2'd2 && !rd_reg) ||
              ((phase_reg == 2'd0 || phase_reg == 2'd3) && sh_next[7:1] == own_addr);
            case (phase_reg)
              2'd0: begin
                rd_reg <= sh_next[0];
                phase_reg <= (sh_next[7:1] == own_addr) ? (sh_next[0] ? 2'd2 : 2'd1) : 2'd3;
                reg_read <= sh_next[0] && sh_next[7:1] == own_addr;
              end
              2'd1: begin
                addr_reg <= {2'b00, sh_next};
                phase_reg <= 2'd2;
                pop_cnt_reg <= 2'd0;
              end
              2'd2: begin
                if (!rd_reg) begin
                  reg_wdata <= sh_next;
                  reg_write <= 1'b1;
                end
                addr_reg <= step_addr(addr_reg);
                pop_cnt_reg <= !at_fifo ? 2'd0 : (pop_cnt_reg == 2'd2) ? 2'd0 : pop_cnt_reg + 2'd1;
                reg_read <= rd_reg;
              end
              default: ;
            endcase
          end
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // output shifter and pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_reg <= 8'h00;
      fifo_word_reg <= '0;
      sda_drive_reg <= 1'b0;
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      if (out_edge) begin
        if (load_tx && at_fifo && pop_cnt_reg == 2'd0) fifo_word_reg <= fifo_bytes;
        if (load_tx) begin
          tx_reg <= {byte_src[6:0], 1'b0};
          miso_out <= byte_src[7];
          sda_drive_reg <= !byte_src[7];
        end else begin
          tx_reg <= {tx_reg[6:0], 1'b0};
          miso_out <= tx_reg[7];
          sda_drive_reg <= i2c_on && rd_reg && phase_reg == 2'd2 && !ack_reg && !tx_reg[7];
        end
        // ack any own-address byte, addressed or not
        if (i2c_on && ack_reg) sda_drive_reg <= ack_drive_reg;
      end
      if (!i2c_on) sda_drive_reg <= 1'b0;
      miso_oe_n <= !spi_on;
      sda_oe_n <= !(i2c_on && sda_drive_reg);
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_addr <= 10'h000;
      i2c_mode <= 1'b0;
    end else begin
      reg_addr <= addr_reg;
      i2c_mode <= i2c_on;
    end
  end
endmodule : sensor_serial_port
`default_nettype wire

// File: core/sensor_port_pkg.sv
// Purpose: shared constants for the dual spi/i2c sensor port
// Assumes: 100 MHz system clock
// Notes: register space is reached only through the serial port
package sensor_port_pkg;
  localparam int ADDR_W = 10;
  localparam logic [9:0] ADDR_TOP = 10'h3FF;
  localparam logic [9:0] FIFO_ADDR_DEF = 10'h011;
  localparam logic [6:0] I2C_ADDR_LOW = 7'h1D;
  localparam logic [6:0] I2C_ADDR_HIGH = 7'h53;
  localparam int FIFO_WORD_W = 21;
  localparam int FIFO_DEPTH_DEF = 8;
  localparam int EMPTY_BIT = 1;
  localparam int XMARK_BIT = 0;
  localparam int BYTES_PER_ENTRY = 3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPI_MAX_KHZ = 10000;
  localparam int I2C_MAX_KHZ = 3400;
  // system clock must give at least ten samples per serial period
  localparam int MIN_CLK_PER_SCLK = (1000000 / SPI_MAX_KHZ) / CLK_PERIOD_NS;
  localparam logic [7:0] SPI_RW_BIT_POS = 8'h01;
endpackage : sensor_port_pkg

// File: core/sample_fifo.sv
// Purpose: sample buffer between sensor core and serial port
// Assumes: single clock domain
// Notes: writes refused while full; source sees in_ready
`timescale 1ns/10ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;
  assign in_ready = (wr_ptr_reg - rd_ptr_reg) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem_reg[rd_ptr_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : sample_fifo
`default_nettype wire

// File: tb/port_checker.sv
// Purpose: pin timing and address walk checks for the serial port
// Assumes: bound to sensor_serial_port
// Notes: address walk is tracked only inside one spi frame
`timescale 1ns/10ps
`default_nettype none
module port_checker
  import sensor_port_pkg::*;
#(
  parameter logic [9:0] FIFO_ADDR = FIFO_ADDR_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cs_scl_pin,
  input wire logic sclk_pin,
  input wire logic sda_oe_n,
  input wire logic miso_out,
  input wire logic miso_oe_n,
  input wire logic [9:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic i2c_mode
);
  // ------------------------------
  // address walk
  // ------------------------------
  logic [9:0] last_reg;
  logic have_reg;
  logic prime_reg;
  logic step;
  // first strobe of a frame may show the address of the frame before
  assign step = (reg_read || reg_write) && have_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      have_reg <= 1'b0;
      prime_reg <= 1'b0;
      last_reg <= 10'h000;
    end else if (cs_scl_pin || i2c_mode) begin
      have_reg <= 1'b0;
      prime_reg <= 1'b0;
    end else if (reg_read || reg_write) begin
      prime_reg <= 1'b1;
      have_reg <= prime_reg;
      last_reg <= reg_addr;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  chk_addr_step: assert property (
    step && last_reg != FIFO_ADDR && last_reg != ADDR_TOP |-> reg_addr == last_reg + 10'h001)
    else $error("address did not step");
  chk_fifo_stay: assert property (
    step && last_reg == FIFO_ADDR |-> reg_addr == FIFO_ADDR)
    else $error("address left fifo");
  chk_read_pulse: assert property (reg_read |=> !reg_read)
    else $error("read strobe too long");
  chk_write_pulse: assert property (reg_write |=> !reg_write)
    else $error("write strobe too long");
  chk_sda_mode: assert property (!sda_oe_n |-> i2c_mode)
    else $error("sda pulled outside i2c");
  chk_miso_mode: assert property (i2c_mode |-> miso_oe_n)
    else $error("miso driven in i2c");
  chk_miso_hold: assert property (
    $rose(sclk_pin) && !miso_oe_n |=> $stable(miso_out) [*3])
    else $error("miso moved after rise");
  chk_sda_scl_low: assert property ($changed(sda_oe_n) |-> !cs_scl_pin)
    else $error("sda moved with scl high");
endmodule : port_checker
bind sensor_serial_port port_checker #(.FIFO_ADDR(FIFO_ADDR)) port_checker_inst (
  .clk(clk), .arst_n(arst_n), .cs_scl_pin(cs_scl_pin), .sclk_pin(sclk_pin), .sda_oe_n(sda_oe_n),
  .miso_out(miso_out), .miso_oe_n(miso_oe_n), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_read(reg_read), .i2c_mode(i2c_mode));
`default_nettype wire

// File: tb/host.sv
// Purpose: host model, spi mode 0 master and i2c master
// Assumes: pins change on falling clk edge
// Notes: sda resolved in the bench with a pull-up
`timescale 1ns/10ps
`default_nettype none
module host (
  input wire logic clk,
  input wire logic miso,
  input wire logic sda,
  output logic cs_scl,
  output logic sclk,
  output logic mosi_sda
);
  // ------------------------------
  // bus cycles
  // ------------------------------
  localparam int H = 15; // 340 ns scl period, below 3.4 MHz
  initial begin
    cs_scl = 1'b1;
    sclk = 1'b0;
    mosi_sda = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic spi_byte(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi_sda = t[i];
      tick(4); // 80 ns period, 12.5 MHz, faster than the 10 MHz limit
      sclk = 1'b1;
      tick(2);
      r[i] = miso;
      tick(2);
      sclk = 1'b0;
    end
    mosi_sda = ~t[0]; // released line shows inverse
  endtask : spi_byte
  task automatic spi(input logic [7:0] cmd, input logic [7:0] t[$], output logic [7:0] r[$]);
    logic [7:0] b;
    r = {};
    cs_scl = 1'b0;
    tick(4);
    spi_byte(cmd, b);
    foreach (t[i]) begin
      spi_byte(t[i], b);
      r.push_back(b);
      tick(6); // stall between bytes
    end
    cs_scl = 1'b1;
    tick(12);
  endtask : spi
  task automatic i2c_bit(input logic b, output logic s);
    tick(4);
    mosi_sda = b;
    tick(H);
    cs_scl = 1'b1;
    tick(H);
    s = sda;
    cs_scl = 1'b0;
  endtask : i2c_bit
  task automatic i2c_byte(input logic [7:0] t, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) i2c_bit(t[i], r[i]);
    i2c_bit(a, k);
  endtask : i2c_byte
  task automatic i2c_start();
    tick(4);
    mosi_sda = 1'b1;
    tick(H);
    cs_scl = 1'b1;
    tick(H);
    mosi_sda = 1'b0;
    tick(H);
    cs_scl = 1'b0;
  endtask : i2c_start
  task automatic i2c_stop();
    tick(4);
    mosi_sda = 1'b0;
    tick(H);
    cs_scl = 1'b1;
    tick(H);
    mosi_sda = 1'b1;
    tick(H);
  endtask : i2c_stop
endmodule : host
`default_nettype wire

// File: tb/tb_sensor_serial_port.sv
// Purpose: self-checking bench for sensor_serial_port
// Assumes: register file modelled as address xor 5A
// Notes: spi first, then i2c at both select levels
`timescale 1ns/10ps
`default_nettype none
module tb_sensor_serial_port;
  import sensor_port_pkg::*;
  logic clk, arst_n, cs_scl, sclk, mosi_sda, sda, sda_out, sda_oe_n, i2c_addr_select_pin, miso_out, miso_oe_n;
  logic reg_write, reg_read, sample_valid, sample_ready, i2c_mode;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic [20:0] sample_data, w;
  logic [7:0] tx[$], rx[$];
  logic [20:0] wq[$];
  logic [17:0] wrq[$];
  logic k;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  // ------------------------------
  // wiring and checks
  // ------------------------------
  assign sda = mosi_sda & (sda_oe_n | sda_out);
  assign reg_rdata = reg_addr[7:0] ^ 8'h5A;
  sensor_serial_port #(.FIFO_DEPTH(FIFO_DEPTH_DEF), .FIFO_ADDR(FIFO_ADDR_DEF)) sensor_serial_port_inst (
    .clk(clk), .arst_n(arst_n), .cs_scl_pin(cs_scl), .sclk_pin(sclk), .mosi_sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .miso_i2c_addr_select_pin_in(i2c_addr_select_pin), .miso_out(miso_out),
    .miso_oe_n(miso_oe_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready), .i2c_mode(i2c_mode));
  host host_inst (.clk(clk), .miso(miso_out), .sda(sda), .cs_scl(cs_scl), .sclk(sclk), .mosi_sda(mosi_sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // outputs settle after the rising edge, so look at them mid-cycle
  always @(negedge clk) begin
    if (reg_write === 1'b1) wrq.push_back({reg_addr, reg_wdata});
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic finish_test();
    if (mismatches == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  task automatic t_spi();
    tx = {8'h00};
    host_inst.spi({7'h05, 1'b1}, tx, rx);
    cmp(rx[0], 8'h05 ^ 8'h5A);
    tx = {8'h11, 8'hC3, 8'h3C};
    wrq = {};
    host_inst.spi({7'h20, 1'b0}, tx, rx);
    foreach (tx[i]) cmp(wrq[i], {10'h020 + 10'(i), tx[i]});
  endtask : t_spi
  task automatic t_fifo();
    for (int i = 0; i < 9; i++) begin
      sample_data = {4'(i), 16'hC35A, i % 3 == 0};
      sample_valid = 1'b1;
      @(posedge clk);
      if (sample_ready === 1'b1) wq.push_back(sample_data);
      @(negedge clk);
    end
    sample_valid = 1'b0;
    cmp(wq.size(), FIFO_DEPTH_DEF);
    tx = {};
    repeat (29) tx.push_back(8'h00);
    host_inst.spi({7'h0F, 1'b1}, tx, rx);
    cmp(rx[0], 8'h0F ^ 8'h5A);
    cmp(rx[1], 8'h10 ^ 8'h5A);
    foreach (wq[e]) begin
      w = wq[e];
      cmp(rx[2 + 3 * e], w[20:13]);
      cmp(rx[3 + 3 * e], w[12:5]);
      cmp(rx[4 + 3 * e], {w[4:1], 3'b000, w[0]});
    end
    cmp(rx[28][1], 1'b1);
    cmp(sample_ready, 1'b1);
  endtask : t_fifo
  task automatic t_i2c(input logic s);
    logic [6:0] a;
    a = s ? I2C_ADDR_HIGH : I2C_ADDR_LOW;
    i2c_addr_select_pin = s;
    wrq = {};
    host_inst.i2c_start();
    host_inst.i2c_byte({a, 1'b0}, 1'b1, d, k);
    cmp(k, 1'b0);
    host_inst.i2c_byte(8'h30, 1'b1, d, k);
    host_inst.i2c_byte(8'h77, 1'b1, d, k);
    host_inst.i2c_stop();
    cmp(wrq[0], {10'h030, 8'h77});
    host_inst.i2c_start();
    host_inst.i2c_byte({a, 1'b0}, 1'b1, d, k);
    host_inst.i2c_byte(8'h06, 1'b1, d, k);
    host_inst.i2c_start();
    host_inst.i2c_byte({a, 1'b1}, 1'b1, d, k);
    host_inst.i2c_byte(8'hFF, 1'b1, d, k);
    host_inst.i2c_stop();
    cmp(d, 8'h06 ^ 8'h5A);
    host_inst.i2c_start();
    host_inst.i2c_byte({7'h2A, 1'b0}, 1'b1, d, k);
    host_inst.i2c_stop();
    cmp(k, 1'b1);
  endtask : t_i2c
  initial begin
    arst_n = 1'b0;
    i2c_addr_select_pin = 1'b0;
    sample_valid = 1'b0;
    sample_data = 21'h000000;
    repeat (6) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_spi();
    t_fifo();
    t_i2c(1'b0);
    t_i2c(1'b1);
    finish_test();
  end
endmodule : tb_sensor_serial_port
`default_nettype wire
